// ### hdl/swf_flash_ctrl.sv
// Top of the single-wire flash control: word pairing, settings, flash
// and torch control, safety timer and an APB register slave.
// Assumes pclk at 200 MHz and pins synchronous to it.
//
// Summary of operation
// [R1] Wire high enables, long low disables
// [R2] Each rising edge counts one pulse; the first rise of a frame only zeroes the count
// [R3] High gap past latch timeout latches word
// [R4] Host keeps each phase within limits
// [R5] Address word then data word form a write
// [R6] Five settings held for the analog blocks
// [R7] Long low shuts down, restores defaults
// [R8] Pin rising edge starts flash mode
// [R9] Flash ends: pin low, flash setting zero
// [R10] Safety timer defaults to its reset codes
// [R11] Low battery level defaults to its code
// [R12] Addresses one to five pick the setting
// [R13] Frame opens on fall, first rise zeroes
// [R14] Words above a setting's maximum dropped
// [R15] Over-threshold current cut at timer end
// [R16] Phases timed in clock cycles, synced
`timescale 1ns/1ps
module swf_flash_ctrl
  import swf_pkg::*;
#(
  parameter int unsigned LATCH_CYC     = LATCH_CYC_DEF,
  parameter int unsigned END_CYC       = END_CYC_DEF,
  parameter int unsigned SAFE_STEP_CYC = SAFE_STEP_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ctrl_wire,
  input  wire logic        flash_enable_pin,
  output logic             dev_enable,
  output logic             flash_on,
  output logic             torch_on,
  output logic      [4:0]  led_code,
  output logic             safety_trip,
  output logic      [4:0]  low_battery_detect
);
  logic        rx_word;      // Latched word strobe
  logic [4:0]  rx_val;       // Latched pulse count
  logic        rx_over;      // Count overflowed
  logic        rx_err;       // Frame discarded
  logic        rx_shut;      // Entered shutdown
  logic        rx_en;        // Device awake
  logic [1:0]  ctrl_reg;     // Software control bits
  logic [4:0]  flash_reg;    // Flash current setting
  logic [4:0]  torch_reg;    // Torch current setting
  logic [4:0]  dur_reg;      // Safety timer duration
  logic [4:0]  thr_reg;      // Safety current threshold
  logic [4:0]  lowbat_reg;   // Low battery level code
  logic        pend_reg;     // Address word received
  logic [4:0]  addr_reg;     // Pending address
  logic        fen_d_reg;    // Pin one cycle ago
  logic        flash_reg_on; // Flash mode active
  logic        torch_reg_on; // Torch mode active
  logic [4:0]  led_reg;      // Current code to the sink
  logic        trip_reg;     // Safety cut-off latched
  logic        en_reg;       // Enable to the outside
  logic [31:0] step_cnt_reg; // Cycles in a timer step
  logic [5:0]  steps_reg;    // Timer steps elapsed
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic        fen_rise;
  logic        over;
  logic [4:0]  cur_code;
  logic        setup;
  logic        wr_acc;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Largest legal value per address, zero for unknown addresses
  function automatic logic [4:0] reg_max(input logic [4:0] a);
    case (a) // [R12]
      ADR_FLASH:  reg_max = MAX_FLASH;
      ADR_TORCH:  reg_max = MAX_TORCH;
      ADR_DUR:    reg_max = MAX_DUR;
      ADR_LOWBAT: reg_max = MAX_LOWBAT;
      ADR_THR:    reg_max = MAX_THR;
      default:    reg_max = 5'h00;
    endcase
  endfunction

  swf_wire_rx #(
    .LATCH_CYC (LATCH_CYC),
    .END_CYC   (END_CYC)
  ) u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .ctrl_wire (ctrl_wire),
    .word_stb  (rx_word),
    .word_val  (rx_val),
    .word_over (rx_over),
    .err_stb   (rx_err),
    .shut_stb  (rx_shut),
    .enabled   (rx_en)
  );

  // Word pairing and the five settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reg  <= FLASH_DEF;
      torch_reg  <= TORCH_DEF;
      dur_reg    <= DUR_DEF;    // [R10]
      thr_reg    <= THR_DEF;    // [R10]
      lowbat_reg <= LOWBAT_DEF; // [R11]
      pend_reg   <= 1'b0;
      addr_reg   <= 5'h00;
    end else if (rx_shut) begin // [R7]
      flash_reg  <= FLASH_DEF;
      torch_reg  <= TORCH_DEF;
      dur_reg    <= DUR_DEF;
      thr_reg    <= THR_DEF;
      lowbat_reg <= LOWBAT_DEF;
      pend_reg   <= 1'b0;
    end else if (rx_err) begin
      // A broken frame also drops a half-received pair
      pend_reg <= 1'b0;
    end else if (rx_word && ctrl_reg[CTRL_SER]) begin
      if (rx_over) begin // [R14]
        pend_reg <= 1'b0;
      end else if (!pend_reg) begin // [R5]
        if (reg_max(rx_val) != 5'h00) begin
          pend_reg <= 1'b1;
          addr_reg <= rx_val;
        end
      end else begin
        pend_reg <= 1'b0;
        // Over-range data is silently dropped [R14]
        if (rx_val <= reg_max(addr_reg)) begin
          case (addr_reg) // [R6] [R12]
            ADR_FLASH:  flash_reg  <= rx_val;
            ADR_TORCH:  torch_reg  <= rx_val;
            ADR_DUR:    dur_reg    <= rx_val;
            ADR_LOWBAT: lowbat_reg <= rx_val;
            ADR_THR:    thr_reg    <= rx_val;
            default:    pend_reg   <= 1'b0;
          endcase
        end
      end
    end
  end

  // Flash and torch modes; flash wins over torch
  assign fen_rise = flash_enable_pin && !fen_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fen_d_reg    <= 1'b0;
      flash_reg_on <= 1'b0;
      torch_reg_on <= 1'b0;
    end else begin
      fen_d_reg <= flash_enable_pin;
      // Held by pin or setting; ends when both are off or the device is disabled [R8] [R9]
      flash_reg_on <= rx_en && (fen_rise || flash_reg != 5'h00
                      || (flash_reg_on && flash_enable_pin));
      torch_reg_on <= rx_en && (torch_reg != 5'h00);
    end
  end

  // Current that the active mode asks for
  always_comb begin
    cur_code = 5'h00;
    if (flash_reg_on) begin
      cur_code = (flash_reg != 5'h00) ? flash_reg : FLASH_PIN_CODE;
    end else if (torch_reg_on) begin
      cur_code = torch_reg;
    end
  end

  assign over = ctrl_reg[CTRL_SAFE] && (cur_code > thr_reg);

  // Safety timer: dur_reg + 1 steps of SAFE_STEP_CYC cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= 32'h00000000;
      steps_reg    <= 6'h00;
      trip_reg     <= 1'b0;
    end else begin
      if (!over || trip_reg) begin
        step_cnt_reg <= 32'h00000000;
        steps_reg    <= 6'h00;
      end else if (step_cnt_reg == SAFE_STEP_CYC - 1) begin
        step_cnt_reg <= 32'h00000000;
        steps_reg    <= steps_reg + 6'h01;
      end else begin
        step_cnt_reg <= step_cnt_reg + 32'h00000001;
      end
      // Expiry sets; releasing both modes clears, set wins
      if (over && !trip_reg && step_cnt_reg == SAFE_STEP_CYC - 1
          && steps_reg == {1'b0, dur_reg}) begin
        trip_reg <= 1'b1; // [R15]
      end else if (!flash_reg_on && !torch_reg_on) begin
        trip_reg <= 1'b0;
      end
    end
  end

  // Output flops toward the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= 5'h00;
      en_reg  <= 1'b0;
    end else begin
      led_reg <= trip_reg ? 5'h00 : cur_code; // [R15]
      en_reg  <= rx_en; // [R1]
    end
  end

  assign dev_enable         = en_reg;
  assign flash_on           = flash_reg_on;
  assign torch_on           = torch_reg_on;
  assign led_code           = led_reg;
  assign safety_trip        = trip_reg;
  assign low_battery_detect = lowbat_reg;

  // APB slave: answer comes in the first access cycle
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready_reg && pwrite;

  // Read mux; settings are read-only from the bus
  always_comb begin
    rd_data = 32'h00000000;
    case (paddr)
      OFS_CTRL:   rd_data = {30'h00000000, ctrl_reg};
      OFS_STATUS: rd_data = {26'h0000000, pend_reg, trip_reg,
                             torch_reg_on, flash_reg_on, en_reg, rx_en};
      OFS_FLASH:  rd_data = {27'h0000000, flash_reg};
      OFS_TORCH:  rd_data = {27'h0000000, torch_reg};
      OFS_DUR:    rd_data = {27'h0000000, dur_reg};
      OFS_THR:    rd_data = {27'h0000000, thr_reg};
      OFS_LOWBAT: rd_data = {27'h0000000, lowbat_reg};
      default:    rd_data = 32'h00000000;
    endcase
  end

  // Answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && (paddr > OFS_LOWBAT || paddr[1:0] != 2'h0);
      prdata_reg  <= (setup && !pwrite) ? rd_data : 32'h00000000;
    end
  end

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_reg <= CTRL_DEF;
    else if (wr_acc && paddr == OFS_CTRL) ctrl_reg <= pwdata[1:0];
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  a_shut_defaults: assert property ( // [R7] [R10] [R11]
    rx_shut |=> (flash_reg == FLASH_DEF && torch_reg == TORCH_DEF
                 && dur_reg == DUR_DEF && thr_reg == THR_DEF
                 && lowbat_reg == LOWBAT_DEF && !pend_reg))
    else $error("shutdown did not restore the settings");
  a_pair_write: assert property ( // [R5] [R12]
    (rx_word && ctrl_reg[CTRL_SER] && pend_reg && !rx_over
     && addr_reg == ADR_TORCH && rx_val <= MAX_TORCH)
    |=> (torch_reg == $past(rx_val)) ##1 (torch_reg_on == (torch_reg != 0)))
    else $error("data word did not reach its setting");
  a_drop_over: assert property ( // [R14]
    (rx_word && ctrl_reg[CTRL_SER] && pend_reg && !rx_over
     && rx_val > reg_max(addr_reg))
    |=> ($stable(flash_reg) && $stable(torch_reg) && $stable(dur_reg)
         && $stable(thr_reg) && $stable(lowbat_reg) && !pend_reg))
    else $error("over-range word changed a setting");
  a_fen_start: assert property ( // [R8]
    (fen_rise && rx_en) |=> flash_reg_on ##1 (led_reg != 5'h00 || trip_reg))
    else $error("pin edge did not start flash");
  a_flash_end: assert property ( // [R9]
    (flash_reg_on && !flash_enable_pin && flash_reg == 5'h00)
    |=> !flash_reg_on)
    else $error("flash mode outlived pin and setting");
  a_flash_hold: assert property ( // [R9]
    (flash_reg_on && flash_enable_pin && rx_en) |=> flash_reg_on)
    else $error("flash mode ended with the pin high");
  a_safety_cut: assert property ( // [R15]
    (over && !trip_reg && step_cnt_reg == SAFE_STEP_CYC - 1
     && steps_reg == {1'b0, dur_reg}) |=> trip_reg ##1 (led_reg == 5'h00))
    else $error("safety expiry did not cut the current");

  c_word_write: cover property (rx_word && pend_reg && !rx_over);
  c_shutdown:   cover property (rx_shut);
  c_fen_flash:  cover property (fen_rise ##1 flash_reg_on);
  c_trip:       cover property ($rose(trip_reg));
endmodule

// ### hdl/swf_pkg.sv
// Constants, types and the register map of the single-wire flash control.
// Assumes a 200 MHz pclk; the wire and pin arrive synchronous to it.
package swf_pkg;
  // Clock rate and timing figures
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned TON_MIN_NS    = 100;  // Shortest wire phase
  localparam int unsigned TON_CYC       = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LATCH_US      = 97;   // Shortest latch gap
  localparam int unsigned LATCH_CYC_DEF = LATCH_US * CLK_MHZ;
  localparam int unsigned END_US        = 405;  // Shutdown low time
  localparam int unsigned END_CYC_DEF   = END_US * CLK_MHZ;
  localparam int unsigned SAFE_TO_MS    = 1250; // Default safety time

  // Word addresses carried by the first word of a pair
  localparam logic [4:0] ADR_FLASH  = 5'h01;
  localparam logic [4:0] ADR_TORCH  = 5'h02;
  localparam logic [4:0] ADR_DUR    = 5'h03;
  localparam logic [4:0] ADR_LOWBAT = 5'h04;
  localparam logic [4:0] ADR_THR    = 5'h05;

  // Largest legal value per setting
  localparam logic [4:0] MAX_FLASH  = 5'h10;
  localparam logic [4:0] MAX_TORCH  = 5'h10;
  localparam logic [4:0] MAX_DUR    = 5'h0F;
  localparam logic [4:0] MAX_LOWBAT = 5'h07;
  localparam logic [4:0] MAX_THR    = 5'h10;

  // Reset values of the settings
  localparam logic [4:0] FLASH_DEF  = 5'h00;
  localparam logic [4:0] TORCH_DEF  = 5'h00;
  localparam logic [4:0] DUR_DEF    = 5'h07;  // Eight steps of the timer
  localparam logic [4:0] THR_DEF    = 5'h05;  // Code for the default limit
  localparam logic [4:0] LOWBAT_DEF = 5'h03;  // Code for the default level
  localparam logic [4:0] FLASH_PIN_CODE = 5'h10; // Current under pin only
  localparam int unsigned SAFE_STEP_DEF =
    SAFE_TO_MS * CLK_MHZ * 1000 / (DUR_DEF + 1);

  // Pulse counter saturation
  localparam logic [4:0] CNT_SAT = 5'h1F;

  // APB byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLASH  = 8'h08;
  localparam logic [7:0] OFS_TORCH  = 8'h0C;
  localparam logic [7:0] OFS_DUR    = 8'h10;
  localparam logic [7:0] OFS_THR    = 8'h14;
  localparam logic [7:0] OFS_LOWBAT = 8'h18;

  // Control bits and reset
  localparam int unsigned CTRL_SER  = 0;
  localparam int unsigned CTRL_SAFE = 1;
  localparam logic [1:0]  CTRL_DEF  = 2'h3;

  // Receiver states, Gray along shutdown, idle, frame, error
  typedef enum logic [1:0] {
    RX_SHUT  = 2'b00,
    RX_IDLE  = 2'b01,
    RX_FRAME = 2'b11,
    RX_ERR   = 2'b10
  } swf_rx_state_e;
endpackage

// ### hdl/swf_wire_rx.sv
// Receiver for the pulse-counting control wire: filter, frame, latch.
// Assumes ctrl_wire synchronous to pclk; one sync stage pair still added.
`timescale 1ns/1ps
module swf_wire_rx
  import swf_pkg::*;
#(
  parameter int unsigned LATCH_CYC = LATCH_CYC_DEF,
  parameter int unsigned END_CYC   = END_CYC_DEF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ctrl_wire,
  output logic            word_stb,
  output logic [4:0]      word_val,
  output logic            word_over,
  output logic            err_stb,
  output logic            shut_stb,
  output logic            enabled
);
  logic          sync1_reg;   // First sync stage, read by sync2 only
  logic          sync2_reg;   // Second sync stage
  logic          lvl_reg;     // Filtered wire level
  logic [7:0]    flt_cnt_reg; // Cycles the new level has held
  logic [31:0]   phase_reg;   // Cycles since last filtered edge
  logic [4:0]    cnt_reg;     // Pulse counter
  logic          first_reg;   // Waiting for first rising edge
  logic          over_reg;    // Counter overflowed
  swf_rx_state_e state_reg;
  logic          flip;
  logic          rise;
  logic          fall;
  logic          latch_hit;
  logic          low_hit;
  logic          end_hit;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= ctrl_wire;
      sync2_reg <= sync1_reg; // [R16]
    end
  end

  // Glitch filter: a level must hold the shortest phase to count
  assign flip = (sync2_reg != lvl_reg) && (flt_cnt_reg == TON_CYC - 1);
  assign rise = flip && sync2_reg;
  assign fall = flip && !sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg     <= 1'b0;
      flt_cnt_reg <= 8'h00;
    end else if (sync2_reg == lvl_reg) begin
      flt_cnt_reg <= 8'h00;
    end else if (flip) begin // [R16]
      lvl_reg     <= sync2_reg;
      flt_cnt_reg <= 8'h00;
    end else begin
      flt_cnt_reg <= flt_cnt_reg + 8'h01;
    end
  end

  // Phase timer, saturating so long levels never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 32'h00000000;
    end else if (flip) begin
      phase_reg <= 32'h00000000;
    end else if (phase_reg != 32'hFFFFFFFF) begin
      phase_reg <= phase_reg + 32'h00000001;
    end
  end

  assign latch_hit = lvl_reg && (phase_reg == LATCH_CYC - 1);
  assign low_hit   = !lvl_reg && (phase_reg == LATCH_CYC - 1);
  assign end_hit   = !lvl_reg && (phase_reg == END_CYC - 1);

  // Frame state machine; shutdown overrides any state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RX_SHUT;
      cnt_reg   <= 5'h00;
      first_reg <= 1'b0;
      over_reg  <= 1'b0;
      word_stb  <= 1'b0;
      word_val  <= 5'h00;
      word_over <= 1'b0;
      err_stb   <= 1'b0;
      shut_stb  <= 1'b0;
    end else begin
      word_stb <= 1'b0;
      err_stb  <= 1'b0;
      shut_stb <= 1'b0;
      if (end_hit && state_reg != RX_SHUT) begin // [R7]
        state_reg <= RX_SHUT;
        shut_stb  <= 1'b1;
      end else begin
        case (state_reg)
          RX_SHUT: begin
            // Wire high wakes the device [R1]
            if (rise) state_reg <= RX_IDLE;
          end
          RX_IDLE: begin
            // First falling edge opens a frame [R13]
            if (fall) begin
              state_reg <= RX_FRAME;
              first_reg <= 1'b1;
              cnt_reg   <= 5'h00;
              over_reg  <= 1'b0;
            end
          end
          RX_FRAME: begin
            if (rise) begin
              if (first_reg) begin
                first_reg <= 1'b0; // [R13]
                cnt_reg   <= 5'h00;
              end else if (cnt_reg == CNT_SAT) begin
                over_reg <= 1'b1;
              end else begin
                cnt_reg <= cnt_reg + 5'h01; // [R2]
              end
            end else if (latch_hit) begin // [R3]
              word_stb  <= 1'b1;
              word_val  <= cnt_reg;
              word_over <= over_reg;
              state_reg <= RX_IDLE;
            end else if (low_hit) begin
              // Low too long for data: discard the frame
              err_stb   <= 1'b1;
              state_reg <= RX_ERR;
            end
          end
          RX_ERR: begin
            if (rise) state_reg <= RX_IDLE;
          end
          default: state_reg <= RX_SHUT;
        endcase
      end
    end
  end

  // Device enable follows the shutdown state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enabled <= 1'b0;
    else enabled <= (state_reg != RX_SHUT);
  end

  a_filter_hold: assert property ( // [R16]
    (lvl_reg != $past(lvl_reg)) |->
      ($past(sync2_reg, TON_CYC) == lvl_reg))
    else $error("filtered level changed before the minimum phase");
  a_count_step: assert property ( // [R2]
    (state_reg == RX_FRAME && rise && !first_reg && cnt_reg != CNT_SAT
     && !end_hit) |=> (cnt_reg == $past(cnt_reg) + 5'h01))
    else $error("pulse did not advance the counter");
  a_latch_gap: assert property ( // [R3]
    $rose(word_stb) |-> $past(lvl_reg) && $past(state_reg) == RX_FRAME)
    else $error("word latched without a high gap");
  a_wire_enable: assert property ( // [R1]
    (state_reg == RX_SHUT && rise) |-> ##2 enabled)
    else $error("wire high did not enable the device");
endmodule

// ### test/swf_host_wire.sv
// Host GPIO model that drives the single control wire of the flash control.
// Assumes the caller enters each task just after a rising pclk edge.
`timescale 1ns/1ps
module swf_host_wire #(
  parameter int unsigned PH  = 24,  // Cycles per wire phase
  parameter int unsigned GAP = 260  // Extra high cycles after a word
) (
  input  wire logic pclk,
  output logic      ctrl_wire
);
  // Wire has a pull-down, so it sits low until the host drives it
  initial ctrl_wire = 1'b0;

  // Drive one level and hold it for a number of cycles
  task automatic level(input logic v, input int unsigned n);
    ctrl_wire <= v;
    repeat (n) @(posedge pclk);
  endtask

  // One word: value plus one pulses, then a long high to latch it
  task automatic send_word(input int unsigned val);
    for (int i = 0; i <= val; i++) begin
      level(1'b0, PH);
      level(1'b1, PH);
    end
    // Gap well past the latch time so latching is certain
    level(1'b1, GAP);
  endtask

  // Address word then data word
  task automatic write_reg(input int unsigned a, input int unsigned v);
    send_word(a);
    send_word(v);
  endtask
endmodule

// ### test/swf_flash_ctrl_bench.sv
// Self-checking bench of the flash control: APB reads and wire writes.
// Assumes short latch, shutdown and safety counts set by parameter.
`timescale 1ns/1ps
module swf_flash_ctrl_bench;
  import swf_pkg::*;
  localparam int unsigned LAT  = 200;  // Short latch count
  localparam int unsigned ENDC = 800;  // Short shutdown count
  localparam int unsigned STEP = 50;   // Short safety step
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ctrl_wire, flash_enable_pin;
  logic        dev_enable, flash_on, torch_on, safety_trip;
  logic [4:0]  led_code, low_battery_detect;
  int          failures, checks_done, cyc, n;
  logic [31:0] rdat;
  logic        rerr;
  // Setting table: address, value, APB offset
  logic [4:0]  tab_a [4] = '{ADR_TORCH, ADR_DUR, ADR_LOWBAT, ADR_THR};
  logic [4:0]  tab_v [4] = '{5'h03, 5'h04, 5'h06, 5'h09};
  logic [7:0]  tab_o [4] = '{OFS_TORCH, OFS_DUR, OFS_LOWBAT, OFS_THR};

  swf_flash_ctrl #(.LATCH_CYC(LAT), .END_CYC(ENDC), .SAFE_STEP_CYC(STEP))
    u_swf_flash_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_wire(ctrl_wire), .flash_enable_pin(flash_enable_pin),
    .dev_enable(dev_enable), .flash_on(flash_on), .torch_on(torch_on),
    .led_code(led_code), .safety_trip(safety_trip),
    .low_battery_detect(low_battery_detect));
  swf_host_wire u_swf_host_wire (.pclk(pclk), .ctrl_wire(ctrl_wire));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Cycle ceiling cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      test_done();
    end
  end

  // Verdict and end of run
  task automatic test_done();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // Main sequence
  initial begin
    cyc = 0;
    failures = 0;
    checks_done = 0;
    {psel, penable, pwrite, flash_enable_pin} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_DUR, {27'h0, DUR_DEF});
    rd(OFS_THR, {27'h0, THR_DEF});
    chk({27'h0, low_battery_detect}, {27'h0, LOWBAT_DEF});
    chk({31'h0, dev_enable}, 32'h0000_0000);
    u_swf_host_wire.level(1'b1, 40);
    chk({31'h0, dev_enable}, 32'h0000_0001);
    // Flash setting written over the wire
    u_swf_host_wire.write_reg(ADR_FLASH, 2);
    rd(OFS_FLASH, 32'h0000_0002);
    chk({31'h0, flash_on}, 32'h0000_0001);
    chk({27'h0, led_code}, 32'h0000_0002);
    // Every other address once
    for (int i = 0; i < 4; i++) begin
      u_swf_host_wire.write_reg(tab_a[i], tab_v[i]);
      rd(tab_o[i], {27'h0, tab_v[i]});
    end
    chk({31'h0, torch_on}, 32'h0000_0001);
    // Value above its maximum is dropped, pairing restarts
    u_swf_host_wire.write_reg(ADR_LOWBAT, 8);
    chk({27'h0, low_battery_detect}, 32'h0000_0006);
    u_swf_host_wire.write_reg(ADR_TORCH, 0);
    rd(OFS_TORCH, 32'h0000_0000);
    u_swf_host_wire.write_reg(ADR_FLASH, 0);
    chk({31'h0, flash_on}, 32'h0000_0000);
    // Pin starts flash; pin code is above threshold, so timer trips
    flash_enable_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, flash_on}, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    chk({31'h0, safety_trip}, 32'h0000_0000);
    n = 0;
    while (safety_trip !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk({31'h0, safety_trip}, 32'h0000_0001);
    chk({27'h0, led_code}, 32'h0000_0000);
    flash_enable_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, flash_on}, 32'h0000_0000);
    // Serial words ignored while disabled in the control register
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    rd(OFS_CTRL, 32'h0000_0002);
    u_swf_host_wire.write_reg(ADR_TORCH, 7);
    rd(OFS_TORCH, 32'h0000_0000);
    // Safety check off: pin flash above threshold never trips
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    flash_enable_pin <= 1'b1;
    repeat (300) @(posedge pclk);
    chk({31'h0, safety_trip}, 32'h0000_0000);
    chk({27'h0, led_code}, {27'h0, FLASH_PIN_CODE});
    rd(OFS_STATUS, 32'h0000_0007);
    flash_enable_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, flash_on}, 32'h0000_0000);
    // Register keeps flash on after the pin falls
    u_swf_host_wire.write_reg(ADR_FLASH, 1);
    flash_enable_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    flash_enable_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, flash_on}, 32'h0000_0001);
    // Long low: shutdown and defaults
    u_swf_host_wire.level(1'b0, ENDC + 60);
    chk({31'h0, dev_enable}, 32'h0000_0000);
    chk({31'h0, flash_on}, 32'h0000_0000);
    rd(OFS_DUR, {27'h0, DUR_DEF});
    rd(OFS_FLASH, 32'h0000_0000);
    chk({27'h0, low_battery_detect}, {27'h0, LOWBAT_DEF});
    // Unmapped offset is refused
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    test_done();
  end
endmodule
